// ===== src/step_seq_params.svh
// Constants for the step sequencer: slot counts, level limits, period codes,
// register offsets and time figures. Included by the sequencer top and the bench.
// Assumes level codes are 16-bit counts where 10000 counts is full scale.
`ifndef STEP_SEQ_PARAMS_SVH
`define STEP_SEQ_PARAMS_SVH
`define SLOTS 100
`define SLOT_LAST 7'h63
`define FP_SLOT_MAX 7'h09
`define EXT_SLOT_MIN 7'h0a
`define RATED_V 16'h2710
`define RATED_I 16'h2710
`define OVT_MAX 16'h2af8
`define OCT_MAX 16'h2af8
`define SENSE_ON_LVL 16'h01f4
`define SENSE_OFF_LVL 16'h00c8
`define PER_OFF 14'h0000
`define PER_JUMP 14'h270e
`define PER_HOLD 14'h270f
`define PER_ONE 14'h0001
`define PER_DEF 14'h0000
`define PGL_LIMIT_MV 12'h9c4
`define PROG_LINES 4
`define CLK_MHZ 25
`define TICK_US 1000
`define BLINK_US 250000
`define A_CTRL 8'h00
`define A_SLOT_SEL 8'h04
`define A_VSET 8'h08
`define A_ISET 8'h0c
`define A_OVT 8'h10
`define A_OCT 8'h14
`define A_PERIOD 8'h18
`define A_STATUS 8'h1c
`define CTRL_RST 3'h3
`define F_V 3'h0
`define F_I 3'h1
`define F_OVT 3'h2
`define F_OCT 3'h3
`define F_PER 3'h4
`endif

// ===== src/step_seq_pkg.sv
// Types shared by the step sequencer design.
// Assumes nothing beyond a SystemVerilog compiler.
package step_seq_pkg;
	typedef enum logic [2:0] {ST_IDLE, ST_ARMED, ST_EVAL, ST_RUN, ST_HOLD, ST_STOPPED} seq_state_t;
	typedef logic [15:0] level_t;
	typedef logic [13:0] period_t;
	typedef logic [6:0] slot_t;
	typedef logic [11:0] mv_t;
endpackage : step_seq_pkg

// ===== src/step_sequencer.sv
// Step sequencer with 100 parameter slots, sense selector and program-line fault.
// Assumes keys and rear inputs arrive as one-cycle pulses synchronous to I_CORE_CLK.
// Notes on behaviour
// RQ1 - A hundred slots hold voltage, current, two trip levels and a period each.
// RQ2 - Front panel writes reach slots 0 to 9; the bus reaches all 100.
// RQ3 - An extended-slot flag shows while the active slot is 10 or above.
// RQ4 - Voltage set point defaults to zero and never exceeds the rating.
// RQ5 - Current set point defaults to zero and never exceeds the rating.
// RQ6 - Voltage trip defaults to and is clamped at 110 percent of rating.
// RQ7 - Current trip defaults to and is clamped at 110 percent of rating.
// RQ8 - The program must be armed before a start can launch it.
// RQ9 - A start while armed begins running the stored slots.
// RQ10 - Running steps advance on period expiry or on another start.
// RQ11 - A slot with period zero turns the output off.
// RQ12 - A slot with period 9999 holds the output on with no timeout.
// RQ13 - A slot with period 9998 jumps back to slot 0 and continues.
// RQ14 - A stop ends the running program at its present step.
// RQ15 - A start after a stop resumes at the slot that was active.
// RQ16 - The memory step key moves the active slot and its parameters, except in ST_EVAL or during a fault.
// RQ17 - With remote sense set, sensing starts local whenever the output is enabled.
// RQ18 - Sensing turns remote once output reaches five percent of full scale with I_LEADS_OK high.
// RQ19 - Remote sensing holds above two percent and drops back to local below.
// RQ20 - The sense lamp flashes while remote is set but local is in use.
// RQ21 - Any programming input over 2.50 V sets the program-line fault, output off.
// RQ22 - Faults stay latched until a clear request arrives.
// RQ23 - Rear start, stop, arm and clear act only with external control enabled.
// RQ24 - Each period unit is one time base tick of parameter length.
// RQ25 - A start while idle is ignored and keeps the slot.
`include "step_seq_params.svh"
module step_sequencer #(
	parameter int unsigned TICK_CYCLES = `TICK_US * `CLK_MHZ,
	parameter int unsigned BLINK_CYCLES = `BLINK_US * `CLK_MHZ
) (
	// Clock and reset.
	input wire logic I_CORE_CLK,
	input wire logic I_RST,
	// APB slave.
	input wire logic I_PSEL,
	input wire logic I_PENABLE,
	input wire logic I_PWRITE,
	input wire logic [7:0] I_PADDR,
	input wire logic [31:0] I_PWDATA,
	output logic [31:0] O_PRDATA,
	output logic O_PREADY,
	output logic O_PSLVERR,
	// Front panel keys.
	input wire logic I_KEY_ARM,
	input wire logic I_KEY_START,
	input wire logic I_KEY_STOP,
	input wire logic I_KEY_CLEAR,
	input wire logic I_KEY_MEM_STEP,
	// Rear digital inputs.
	input wire logic I_EXT_ARM,
	input wire logic I_EXT_START,
	input wire logic I_EXT_STOP,
	input wire logic I_EXT_CLEAR,
	// Front panel slot editing.
	input wire logic I_FP_WR,
	input wire step_seq_pkg::slot_t I_FP_SLOT,
	input wire logic [2:0] I_FP_FIELD,
	input wire logic [15:0] I_FP_DATA,
	// Analog measurements.
	input wire step_seq_pkg::level_t I_OUT_VOLT,
	input wire logic I_LEADS_OK,
	input wire logic [`PROG_LINES*12-1:0] I_PROG_MV,
	// Regulation targets and indicators.
	output step_seq_pkg::level_t O_VSET,
	output step_seq_pkg::level_t O_ISET,
	output step_seq_pkg::level_t O_OVT,
	output step_seq_pkg::level_t O_OCT,
	output step_seq_pkg::slot_t O_SLOT,
	output logic O_MEM_EXT,
	output logic O_OUTPUT_ON,
	output logic O_ARMED,
	output logic O_RUNNING,
	output logic O_SENSE_REMOTE,
	output logic O_RSENSE_LED,
	output logic O_PGL_FAULT
);
	import step_seq_pkg::*;

	localparam logic [23:0] TICK_LAST = 24'(TICK_CYCLES - 1);
	localparam logic [23:0] BLINK_LAST = 24'(BLINK_CYCLES - 1);

	default clocking cb @(posedge I_CORE_CLK); endclocking
	default disable iff (I_RST);

	////////////////////////////////////////////////////////////////////////////
	// Slot storage.
	level_t mem_v [`SLOTS];
	level_t mem_i [`SLOTS];
	level_t mem_ovt [`SLOTS];
	level_t mem_oct [`SLOTS];
	period_t mem_p [`SLOTS];

	seq_state_t state_q;
	slot_t slot_q;
	slot_t sel_q;
	logic [2:0] ctrl_q;
	period_t cnt_q;
	logic [23:0] tick_q;
	logic [23:0] blink_q;
	logic blink_ph_q;
	logic out_on_q;
	logic remote_q;
	logic pgl_q;
	logic pready_q;
	logic pslverr_q;
	logic [31:0] prdata_q;
	level_t vset_q, iset_q, ovt_q, oct_q;
	logic mem_ext_q, rled_q;

	// Limits a level to its ceiling.
	function automatic level_t clamp(input level_t val, input level_t lim);
		clamp = (val > lim) ? lim : val;
	endfunction : clamp

	////////////////////////////////////////////////////////////////////////////
	// Request gating by the control enables.
	logic int_en, ext_en, rsen_cfg;
	logic arm_req, start_req, stop_req, clear_req;
	assign int_en = ctrl_q[0];
	assign ext_en = ctrl_q[1];
	assign rsen_cfg = ctrl_q[2];
	assign arm_req = (I_KEY_ARM & int_en) | (I_EXT_ARM & ext_en); // [RQ23]
	assign start_req = (I_KEY_START & int_en) | (I_EXT_START & ext_en); // [RQ23]
	assign stop_req = (I_KEY_STOP & int_en) | (I_EXT_STOP & ext_en); // [RQ23]
	assign clear_req = (I_KEY_CLEAR & int_en) | (I_EXT_CLEAR & ext_en); // [RQ23]

	////////////////////////////////////////////////////////////////////////////
	// APB decode; one wait state so read data can be registered.
	logic apb_acc, apb_wr;
	logic addr_ok;
	logic [31:0] rd_data;
	assign apb_acc = I_PSEL & I_PENABLE & ~pready_q;
	assign apb_wr = I_PSEL & I_PENABLE & pready_q & I_PWRITE & ~pslverr_q;

	// Read mux and address check.
	always_comb begin
		addr_ok = 1'b1;
		rd_data = 32'h0;
		case (I_PADDR)
			`A_CTRL: rd_data = {29'h0, ctrl_q};
			`A_SLOT_SEL: rd_data = {25'h0, sel_q};
			`A_VSET: rd_data = {16'h0, mem_v[sel_q]};
			`A_ISET: rd_data = {16'h0, mem_i[sel_q]};
			`A_OVT: rd_data = {16'h0, mem_ovt[sel_q]};
			`A_OCT: rd_data = {16'h0, mem_oct[sel_q]};
			`A_PERIOD: rd_data = {18'h0, mem_p[sel_q]};
			`A_STATUS: rd_data = {16'h0, remote_q, pgl_q, out_on_q, 2'h0, state_q, 1'b0, slot_q};
			default: addr_ok = 1'b0;
		endcase
	end

	// Bus answer; pready rises one cycle into the access phase.
	always_ff @(posedge I_CORE_CLK) begin
		if (I_RST) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0;
		end else begin
			pready_q <= apb_acc;
			pslverr_q <= apb_acc & ~addr_ok;
			if (apb_acc) begin
				prdata_q <= I_PWRITE ? 32'h0 : rd_data;
			end
		end
	end

	// Control and slot select; an out of range select saturates at the last slot.
	always_ff @(posedge I_CORE_CLK) begin
		if (I_RST) begin
			ctrl_q <= `CTRL_RST;
			sel_q <= 7'h0;
		end else if (apb_wr && I_PADDR == `A_CTRL) begin
			ctrl_q <= I_PWDATA[2:0];
		end else if (apb_wr && I_PADDR == `A_SLOT_SEL) begin
			sel_q <= (I_PWDATA[6:0] > `SLOT_LAST) ? `SLOT_LAST : I_PWDATA[6:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Slot writes; the bus wins a collision and the panel write is then dropped.
	logic fp_ok;
	slot_t wr_slot;
	logic [2:0] wr_field;
	level_t wr_data;
	logic wr_en;
	assign fp_ok = I_FP_WR & (I_FP_SLOT <= `FP_SLOT_MAX); // [RQ2]
	always_comb begin
		wr_en = 1'b1;
		wr_slot = sel_q;
		wr_data = I_PWDATA[15:0];
		case (I_PADDR)
			`A_VSET: wr_field = `F_V;
			`A_ISET: wr_field = `F_I;
			`A_OVT: wr_field = `F_OVT;
			`A_OCT: wr_field = `F_OCT;
			`A_PERIOD: wr_field = `F_PER;
			default: begin
				wr_field = `F_V;
				wr_en = 1'b0;
			end
		endcase
		if (!(apb_wr && wr_en)) begin
			wr_en = fp_ok; // [RQ2]
			wr_slot = I_FP_SLOT;
			wr_field = I_FP_FIELD;
			wr_data = I_FP_DATA;
		end
	end

	// Storage with defaults at reset and ceilings on every write.
	always_ff @(posedge I_CORE_CLK) begin
		if (I_RST) begin
			for (int k = 0; k < `SLOTS; k++) begin // [RQ1]
				mem_v[k] <= 16'h0; // [RQ4]
				mem_i[k] <= 16'h0; // [RQ5]
				mem_ovt[k] <= `OVT_MAX; // [RQ6]
				mem_oct[k] <= `OCT_MAX; // [RQ7]
				mem_p[k] <= `PER_DEF;
			end
		end else if (wr_en) begin
			case (wr_field)
				`F_V: mem_v[wr_slot] <= clamp(wr_data, `RATED_V); // [RQ4]
				`F_I: mem_i[wr_slot] <= clamp(wr_data, `RATED_I); // [RQ5]
				`F_OVT: mem_ovt[wr_slot] <= clamp(wr_data, `OVT_MAX); // [RQ6]
				`F_OCT: mem_oct[wr_slot] <= clamp(wr_data, `OCT_MAX); // [RQ7]
				`F_PER: mem_p[wr_slot] <= (wr_data[13:0] > `PER_HOLD) ? `PER_HOLD : wr_data[13:0];
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Program-line monitor, one comparator per programming input.
	logic [`PROG_LINES-1:0] over_line;
	logic pgl_now;
	genvar g;
	generate
		for (g = 0; g < `PROG_LINES; g++) begin : g_pgl
			assign over_line[g] = I_PROG_MV[g*12 +: 12] > `PGL_LIMIT_MV; // [RQ21]
		end
	endgenerate
	assign pgl_now = |over_line;

	// Fault latch; a new overrange beats a simultaneous clear.
	always_ff @(posedge I_CORE_CLK) begin
		if (I_RST) begin
			pgl_q <= 1'b0;
		end else if (pgl_now) begin
			pgl_q <= 1'b1; // [RQ21]
		end else if (clear_req) begin
			pgl_q <= 1'b0; // [RQ22]
		end
	end

	AST_PGL_LATCH: assert property (pgl_now |=> O_PGL_FAULT ##1 !O_OUTPUT_ON) // [RQ21]
		else $error("program-line fault did not latch or output stayed on");
	AST_PGL_HOLD: assert property (pgl_q && !clear_req |=> pgl_q) // [RQ22]
		else $error("fault dropped without a clear");

	////////////////////////////////////////////////////////////////////////////
	// Sequencer. A slot chain of 9998 codes with no other slot keeps it evaluating.
	slot_t next_slot;
	logic tick_end, kill;
	assign next_slot = (slot_q == `SLOT_LAST) ? 7'h0 : slot_q + 7'h1;
	assign tick_end = (tick_q == TICK_LAST);
	assign kill = pgl_now | pgl_q;

	always_ff @(posedge I_CORE_CLK) begin
		if (I_RST) begin
			state_q <= ST_IDLE;
			slot_q <= 7'h0;
			cnt_q <= 14'h0;
			tick_q <= 24'h0;
		end else if (kill) begin
			state_q <= ST_IDLE; // [RQ21]
		end else if (I_KEY_MEM_STEP && state_q != ST_EVAL) begin
			slot_q <= next_slot; // [RQ16]
			if (state_q == ST_RUN || state_q == ST_HOLD) begin
				state_q <= ST_EVAL;
			end
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (arm_req) begin
						state_q <= ST_ARMED; // [RQ8] [RQ25]
					end
				end
				ST_ARMED: begin
					if (stop_req) begin
						state_q <= ST_IDLE;
					end else if (start_req) begin
						state_q <= ST_EVAL; // [RQ9]
					end
				end
				ST_EVAL: begin
					tick_q <= 24'h0;
					if (mem_p[slot_q] == `PER_OFF) begin
						state_q <= ST_IDLE; // [RQ11]
					end else if (mem_p[slot_q] == `PER_HOLD) begin
						state_q <= ST_HOLD; // [RQ12]
					end else if (mem_p[slot_q] == `PER_JUMP) begin
						slot_q <= 7'h0; // [RQ13]
					end else begin
						cnt_q <= mem_p[slot_q];
						state_q <= ST_RUN;
					end
				end
				ST_RUN: begin
					if (stop_req) begin
						state_q <= ST_STOPPED; // [RQ14]
					end else if (start_req || (tick_end && cnt_q == `PER_ONE)) begin
						slot_q <= next_slot; // [RQ10]
						state_q <= ST_EVAL;
					end else if (tick_end) begin
						tick_q <= 24'h0; // [RQ24]
						cnt_q <= cnt_q - `PER_ONE;
					end else begin
						tick_q <= tick_q + 24'h1; // [RQ24]
					end
				end
				ST_HOLD: begin
					if (stop_req) begin
						state_q <= ST_STOPPED; // [RQ14]
					end else if (start_req) begin
						slot_q <= next_slot; // [RQ10]
						state_q <= ST_EVAL;
					end
				end
				ST_STOPPED: begin
					if (start_req) begin
						state_q <= ST_EVAL; // [RQ15]
					end else if (arm_req) begin
						state_q <= ST_ARMED;
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	logic quiet;
	assign quiet = !kill && !I_KEY_MEM_STEP;
	AST_NEED_ARM: assert property (state_q == ST_IDLE && start_req |=> state_q != ST_EVAL && $stable(slot_q)) // [RQ8]
		else $error("start launched without arm");
	AST_START: assert property (state_q == ST_ARMED && start_req && !stop_req && quiet |=> state_q == ST_EVAL) // [RQ9]
		else $error("armed start did not launch");
	AST_ZERO_OFF: assert property (state_q == ST_EVAL && mem_p[slot_q] == `PER_OFF && quiet
		|=> state_q == ST_IDLE ##1 !O_OUTPUT_ON) // [RQ11]
		else $error("period zero did not turn output off");
	AST_HOLD_ON: assert property (state_q == ST_HOLD && !start_req && !stop_req && quiet
		|=> state_q == ST_HOLD && O_OUTPUT_ON) // [RQ12]
		else $error("hold slot timed out");
	AST_JUMP: assert property (state_q == ST_EVAL && mem_p[slot_q] == `PER_JUMP && quiet |=> slot_q == 7'h0) // [RQ13]
		else $error("jump code did not return to slot 0");
	AST_STOP: assert property ((state_q == ST_RUN || state_q == ST_HOLD) && stop_req && quiet
		|=> state_q == ST_STOPPED && $stable(slot_q)) // [RQ14]
		else $error("stop did not end program in place");
	AST_RESUME: assert property (state_q == ST_STOPPED && start_req && quiet |=> state_q == ST_EVAL && $stable(slot_q)) // [RQ15]
		else $error("restart did not resume at current slot");
	AST_ADVANCE: assert property (state_q == ST_RUN && start_req && !stop_req && quiet
		|=> slot_q == $past(next_slot)) // [RQ10]
		else $error("extra start did not advance");
	AST_EXT_GATE: assert property (state_q == ST_IDLE && !ext_en && I_EXT_ARM && !I_KEY_ARM |=> state_q == ST_IDLE) // [RQ23]
		else $error("rear arm honoured with external control off");
	AST_EXT_FLAG: assert property (1'b1 |=> O_MEM_EXT == ($past(slot_q) >= `EXT_SLOT_MIN)) // [RQ3]
		else $error("extended slot flag wrong");
	AST_CLAMP: assert property (O_VSET <= `RATED_V && O_OVT <= `OVT_MAX && O_ISET <= `RATED_I) // [RQ4]
		else $error("level above ceiling");

	COV_HOLD: cover property (state_q == ST_HOLD ##1 start_req);
	COV_JUMP: cover property (state_q == ST_EVAL && mem_p[slot_q] == `PER_JUMP);
	COV_RESUME: cover property (state_q == ST_STOPPED ##1 state_q == ST_EVAL);
	COV_REMOTE: cover property (!remote_q ##1 remote_q);

	////////////////////////////////////////////////////////////////////////////
	// Output state and the active slot's parameters.
	always_ff @(posedge I_CORE_CLK) begin
		if (I_RST) begin
			out_on_q <= 1'b0;
			vset_q <= 16'h0;
			iset_q <= 16'h0;
			ovt_q <= `OVT_MAX;
			oct_q <= `OCT_MAX;
			mem_ext_q <= 1'b0;
		end else begin
			// EVAL keeps the old level so a period-zero slot gives no glitch on.
			out_on_q <= !kill && (state_q == ST_RUN || state_q == ST_HOLD || (state_q == ST_EVAL && out_on_q));
			vset_q <= mem_v[slot_q]; // [RQ16]
			iset_q <= mem_i[slot_q];
			ovt_q <= mem_ovt[slot_q];
			oct_q <= mem_oct[slot_q];
			mem_ext_q <= slot_q >= `EXT_SLOT_MIN; // [RQ3]
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Sense selector with 5 percent on and 2 percent off thresholds.
	always_ff @(posedge I_CORE_CLK) begin
		if (I_RST) begin
			remote_q <= 1'b0;
		end else if (!rsen_cfg || !out_on_q) begin
			remote_q <= 1'b0; // [RQ17]
		end else if (!remote_q && I_OUT_VOLT >= `SENSE_ON_LVL && I_LEADS_OK) begin
			remote_q <= 1'b1; // [RQ18]
		end else if (remote_q && I_OUT_VOLT < `SENSE_OFF_LVL) begin
			remote_q <= 1'b0; // [RQ19]
		end
	end

	// Lamp blink; steady when remote, flashing while remote is set but unused.
	always_ff @(posedge I_CORE_CLK) begin
		if (I_RST) begin
			blink_q <= 24'h0;
			blink_ph_q <= 1'b0;
			rled_q <= 1'b0;
		end else begin
			blink_q <= (blink_q == BLINK_LAST) ? 24'h0 : blink_q + 24'h1;
			if (blink_q == BLINK_LAST) begin
				blink_ph_q <= ~blink_ph_q;
			end
			rled_q <= rsen_cfg & (remote_q | blink_ph_q); // [RQ20]
		end
	end

	AST_SENSE_UP: assert property (rsen_cfg && out_on_q && !remote_q && I_OUT_VOLT >= `SENSE_ON_LVL && I_LEADS_OK
		|=> remote_q) // [RQ18]
		else $error("sense did not go remote at 5 percent");
	AST_SENSE_DN: assert property (remote_q && I_OUT_VOLT < `SENSE_OFF_LVL |=> !remote_q) // [RQ19]
		else $error("sense did not return local below 2 percent");

	////////////////////////////////////////////////////////////////////////////
	// Port drive, all from flip-flops except O_ARMED, which is decoded from state_q.
	assign O_PRDATA = prdata_q;
	assign O_PREADY = pready_q;
	assign O_PSLVERR = pslverr_q;
	assign O_VSET = vset_q;
	assign O_ISET = iset_q;
	assign O_OVT = ovt_q;
	assign O_OCT = oct_q;
	assign O_SLOT = slot_q;
	assign O_MEM_EXT = mem_ext_q;
	assign O_OUTPUT_ON = out_on_q;
	assign O_ARMED = (state_q == ST_ARMED);
	assign O_RUNNING = out_on_q;
	assign O_SENSE_REMOTE = remote_q;
	assign O_RSENSE_LED = rled_q;
	assign O_PGL_FAULT = pgl_q;
endmodule : step_sequencer

// ===== verification/step_panel_model.sv
// Model of the operator side: front panel keys and rear control inputs.
// Assumes the bench calls press() from its main thread; keys are idle low.
module step_panel_model (
	// Clock.
	input wire logic i_clk,
	// Key pulses: arm, start, stop, clear, mem step, rear arm, start, stop, clear.
	output logic [8:0] o_keys
);
	////////////////////////////////////////////////////////////////////////////////
	// Keys rest low so that no request leaks between presses.
	initial begin
		o_keys = 9'h000;
	end

	// One press is a single-cycle pulse, launched and dropped just after an edge.
	task automatic press(input logic [8:0] k);
		@(posedge i_clk);
		o_keys <= k;
		@(posedge i_clk);
		o_keys <= 9'h000;
	endtask : press
endmodule : step_panel_model

// ===== verification/step_sequencer_tb.sv
// Self-checking bench for the step sequencer: registers over APB, keys via the panel model.
// Assumes the designer's header and package are compiled first.
`include "step_seq_params.svh"
module step_sequencer_tb;
	import step_seq_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic prdy;
	logic pslverr;
	logic [8:0] keys;
	logic fp_wr = 1'b0;
	slot_t fp_slot = 7'h00;
	logic [2:0] fp_field = 3'h0;
	logic [15:0] fp_data = 16'h0000;
	level_t volt = 16'h0000;
	logic leads = 1'b0;
	logic [47:0] prog = 48'h0;
	level_t vset, iset, overvoltage_trip_level, overcurrent_trip_level;
	slot_t slot;
	logic mem_ext, out_on, armed, running, remote, led, pgl;
	int error_cnt = 0;
	int n_tests = 0;
	int cyc = 0;
	logic [31:0] q;
	logic e;
	logic [31:0] r;
	slot_t s;

	////////////////////////////////////////////////////////////////////////////////
	// Short tick and blink counts keep the run brief.
	step_sequencer #(.TICK_CYCLES(4), .BLINK_CYCLES(8)) DUT (.I_CORE_CLK(clk), .I_RST(rst),
		.I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
		.O_PRDATA(prdata), .O_PREADY(prdy), .O_PSLVERR(pslverr),
		.I_KEY_ARM(keys[0]), .I_KEY_START(keys[1]), .I_KEY_STOP(keys[2]), .I_KEY_CLEAR(keys[3]),
		.I_KEY_MEM_STEP(keys[4]), .I_EXT_ARM(keys[5]), .I_EXT_START(keys[6]), .I_EXT_STOP(keys[7]),
		.I_EXT_CLEAR(keys[8]), .I_FP_WR(fp_wr), .I_FP_SLOT(fp_slot), .I_FP_FIELD(fp_field),
		.I_FP_DATA(fp_data), .I_OUT_VOLT(volt), .I_LEADS_OK(leads), .I_PROG_MV(prog),
		.O_VSET(vset), .O_ISET(iset), .O_OVT(overvoltage_trip_level), .O_OCT(overcurrent_trip_level), .O_SLOT(slot), .O_MEM_EXT(mem_ext),
		.O_OUTPUT_ON(out_on), .O_ARMED(armed), .O_RUNNING(running), .O_SENSE_REMOTE(remote),
		.O_RSENSE_LED(led), .O_PGL_FAULT(pgl));
	step_panel_model u_panel (.i_clk(clk), .o_keys(keys));

	// Free-running core clock and a hang guard well above the expected run.
	always #20 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc > 20000) begin
			error_cnt++;
			close_out();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Comparison, verdict and expectation helpers.
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic close_out();
		$display("checks %0d errors %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : close_out

	function automatic logic [31:0] clampv(input logic [31:0] v, input logic [31:0] m);
		return (v > m) ? m : v;
	endfunction : clampv

	// One APB transfer; the request holds until pready is seen high, then data is taken.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rq,
			output logic re);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (prdy !== 1'b1);
		rq = prdata;
		re = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, q, e);
	endtask : wr

	// Bounded wait for the active slot, then the slot is compared.
	task automatic wait_slot(input slot_t x);
		for (int i = 0; i < 1000 && slot !== x; i++) begin
			@(posedge clk);
		end
		check("slot", {25'h0, slot}, {25'h0, x});
	endtask : wait_slot

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence.
	initial begin
		void'($urandom(32'h708a));
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		check("ovt", overvoltage_trip_level, `OVT_MAX);
		check("oct", overcurrent_trip_level, `OCT_MAX);
		check("vset", vset, 16'h0000);
		check("iset", iset, 16'h0000);
		apb(1'b0, 8'h20, 32'h0, q, e);
		check("unmapped", {q[30:0], e}, 32'h1);
		// Program: slot 0 times out, slot 1 holds, slot 2 jumps back.
		wr(`A_SLOT_SEL, 32'h0);
		wr(`A_PERIOD, 32'h64);
		wr(`A_VSET, 32'hffff);
		apb(1'b0, `A_VSET, 32'h0, q, e);
		check("vset clamp", q, {16'h0, `RATED_V});
		wr(`A_SLOT_SEL, 32'h1);
		wr(`A_PERIOD, 32'h3fff);
		wr(`A_OCT, 32'hffff);
		apb(1'b0, `A_OCT, 32'h0, q, e);
		check("oct clamp", q, {16'h0, `OCT_MAX});
		wr(`A_SLOT_SEL, 32'h2);
		wr(`A_PERIOD, {18'h0, `PER_JUMP});
		// Random bus writes to extended slots read back clamped.
		for (int i = 0; i < 4; i++) begin
			s = 7'(13 + $urandom % 87);
			r = $urandom & 32'hffff;
			wr(`A_SLOT_SEL, {25'h0, s});
			wr(`A_ISET, r);
			apb(1'b0, `A_ISET, 32'h0, q, e);
			check("iset rand", q, clampv(r, {16'h0, `RATED_I}));
		end
		// Panel writes land only in slots 0 to 9.
		for (int i = 0; i < 2; i++) begin
			s = i ? 7'(10 + $urandom % 90) : 7'(1 + $urandom % 9);
			r = $urandom & 32'hffff;
			@(posedge clk);
			fp_wr <= 1'b1;
			fp_slot <= s;
			fp_field <= `F_V;
			fp_data <= r[15:0];
			@(posedge clk);
			fp_wr <= 1'b0;
			wr(`A_SLOT_SEL, {25'h0, s});
			apb(1'b0, `A_VSET, 32'h0, q, e);
			check("panel write", q, i ? 32'h0 : clampv(r, {16'h0, `RATED_V}));
		end
		// Start when idle does nothing; rear arm is ignored without external control.
		u_panel.press(9'h002);
		repeat (3) @(posedge clk);
		check("idle start", {slot, running}, 8'h0);
		wr(`A_CTRL, 32'h1);
		u_panel.press(9'h020);
		check("ext arm off", armed, 1'b0);
		wr(`A_CTRL, 32'h3);
		u_panel.press(9'h020);
		@(posedge clk);
		check("armed", armed, 1'b1);
		u_panel.press(9'h002);
		repeat (4) @(posedge clk);
		check("run", {running, vset}, {1'b1, `RATED_V});
		wait_slot(7'h01);
		repeat (100) @(posedge clk);
		check("hold", {slot, running, overcurrent_trip_level}, {7'h01, 1'b1, `OCT_MAX});
		// Sense selection while the output is on.
		wr(`A_CTRL, 32'h7);
		volt <= 16'(16'h01f4 + $urandom % 9500);
		repeat (5) @(posedge clk);
		r[0] = led;
		repeat (8) @(posedge clk);
		check("no leads", {remote, led}, {1'b0, ~r[0]});
		leads <= 1'b1;
		repeat (5) @(posedge clk);
		check("remote up", remote, 1'b1);
		volt <= 16'(16'h00c8 + $urandom % 300);
		repeat (5) @(posedge clk);
		check("remote held", remote, 1'b1);
		volt <= 16'($urandom % 200);
		repeat (5) @(posedge clk);
		check("local again", remote, 1'b0);
		// Stop, resume at the same slot, then jump and early advance.
		u_panel.press(9'h004);
		repeat (3) @(posedge clk);
		check("stopped", {slot, running}, {7'h01, 1'b0});
		u_panel.press(9'h002);
		repeat (4) @(posedge clk);
		check("resumed", {slot, running}, {7'h01, 1'b1});
		u_panel.press(9'h002);
		wait_slot(7'h00);
		u_panel.press(9'h002);
		repeat (4) @(posedge clk);
		check("early step", slot, 7'h01);
		// Program-line fault latches until cleared.
		prog <= {12'($urandom % 2500), 12'(`PGL_LIMIT_MV + 1 + $urandom % 100), 12'($urandom % 2500), 12'h0};
		repeat (3) @(posedge clk);
		check("pgl set", {pgl, running}, 2'b10);
		prog <= 48'h0;
		repeat (3) @(posedge clk);
		check("pgl held", pgl, 1'b1);
		u_panel.press(9'h008);
		repeat (2) @(posedge clk);
		check("pgl clear", pgl, 1'b0);
		// Period zero turns the output off; stepping reaches the extended slots.
		u_panel.press(9'h010);
		u_panel.press(9'h010);
		u_panel.press(9'h001);
		u_panel.press(9'h002);
		repeat (5) @(posedge clk);
		check("period off", {slot, running, armed}, {7'h03, 2'b00});
		for (int i = 0; i < 7; i++) begin
			u_panel.press(9'h010);
		end
		repeat (2) @(posedge clk);
		check("mem ext", {slot, mem_ext, vset}, {7'h0a, 1'b1, 16'h0});
		close_out();
	end
endmodule : step_sequencer_tb
